// ### hw/sda_cfg.svh
// Offsets, field positions, reset values and timing counts of the alarm block
`ifndef SDA_CFG_SVH
`define SDA_CFG_SVH
// ==========================================
// Register byte offsets
`define SDA_REG_CTRL 8'h00
`define SDA_REG_CMD 8'h04
`define SDA_REG_STATUS 8'h08
`define SDA_REG_ALARM 8'h0C
`define SDA_REG_WARN 8'h10
`define SDA_REG_LIMIT 8'h14
`define SDA_REG_CODE 8'h18
`define SDA_REG_IRQ_STAT 8'h1C
`define SDA_REG_IRQ_MASK 8'h20
`define SDA_REG_TELL 8'h24
`define SDA_REG_HIST 8'h28
// ==========================================
// Field positions
`define SDA_CTRL_WARN_NEG 0
`define SDA_CTRL_LIMIT_NEG 1
`define SDA_CMD_CLEAR 0
`define SDA_CMD_TELL 1
`define SDA_IRQ_ALARM 0
`define SDA_IRQ_WARN 1
`define SDA_IRQ_LIMIT 2
`define SDA_IRQ_HIST 3
// ==========================================
// Reset values: both polarities negative logic
`define SDA_CTRL_RESET 2'h3
`define SDA_IRQ_MASK_RESET 4'h0
// ==========================================
// Alarm bit indices
`define SDA_AL_C3 5
`define SDA_AL_E0 6
`define SDA_AL_E2 7
`define SDA_AL_F4 11
// Warnings that take the servo off: overload, pulse error, excess error, main AC
`define SDA_WARN_SERVO_OFF 7'h4D
// ==========================================
// Timing
`define SDA_CLK_HZ 25000000
`define SDA_INIT_LIMIT_MS 10000
`define SDA_INIT_LIMIT_CYCLES (`SDA_INIT_LIMIT_MS * (`SDA_CLK_HZ / 1000))
`endif

// ### hw/sda_pkg.sv
// Types shared by the alarm and status block
`default_nettype none
package sda_pkg;
    typedef enum logic [5:0] {
        SDA_INIT = 6'h01,
        SDA_SERVO_OFF = 6'h02,
        SDA_ENGAGING = 6'h04,
        SDA_RUNNING = 6'h08,
        SDA_ALARM = 6'h10,
        SDA_CPU_FAIL = 6'h20
    } sda_state_type;
    typedef enum logic [1:0] {
        SDA_LED_OFF = 2'h0,
        SDA_LED_ORANGE = 2'h1,
        SDA_LED_GREEN = 2'h2
    } sda_led_type;
    localparam int SDA_ALARMS = 17;
    localparam int SDA_WARNS = 7;
endpackage
`default_nettype wire

// ### hw/sda_latch_if.sv
// Set, clear and held flags of a bank of sticky event latches
`default_nettype none
interface sda_latch_if #(parameter int W = 8);
    logic [W-1:0] set;
    logic [W-1:0] clr;
    logic [W-1:0] q;
    modport store (input set, input clr, output q);
    modport user (output set, output clr, input q);
endinterface
`default_nettype wire

// ### hw/sda_event_latch.sv
// Bank of independent sticky latches, set winning over clear
`default_nettype none
module sda_event_latch #(
    parameter int W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    sda_latch_if.store lt
);
    // ==========================================
    // One flop per event so that each cause is held on its own
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    lt.q[i] <= 1'b0;
                end else if (lt.set[i]) begin
                    lt.q[i] <= 1'b1;
                end else if (lt.clr[i]) begin
                    lt.q[i] <= 1'b0;
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// ### hw/sda_top.sv
// Servo driver alarm, warning, travel-limit and status output logic with APB registers
// ==========================================
// What this block does
// - Ready for commands: green LED, all status outputs closed, servo on.
// - Ready, warning and limit outputs closed normally, open on abnormality.
// - Warning and limit outputs default to negative logic polarity.
// - During initialisation: orange LED, blank display, outputs open, servo off.
// - Initialisation beyond 10 seconds is a processor error alarm.
// - Servo enable inactive: servo-off code, green LED, servo state open.
// - Servo state output closes only once servo is actually engaged.
// - Dynamic brake applied in every state where the servo is off.
// - Abnormalities are alarm, warning or over-travel limit.
// - Any abnormality outside initialisation and processor failure: orange LED and two-character code shown.
// - Alarm opens driver ready, servo off, brake; warning and limits untouched.
// - Emergency-stop alarm clears when emergency stop input is released.
// - Other alarms hold until power cycle; no input or command clears them.
// - Each alarm cause has its own two-character code.
// - History skips RAM and emergency stop; CPU and ROM only when backup possible.
// - Warning opens warning output; cleared by clear input or command.
// - Limit opens its direction output; only motion out of it accepted.
//
// The register offsets and the APB register port are this design's own decisions.
`default_nettype none
`include "sda_cfg.svh"
module sda_top
    import sda_pkg::*;
#(
    parameter int unsigned INIT_LIMIT_CYCLES = `SDA_INIT_LIMIT_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic init_done_in,
    input wire logic servo_enable_in,
    input wire logic servo_engaged_in,
    input wire logic stop_in,
    input wire logic emergency_stop_in,
    input wire logic fault_clear_in,
    input wire logic [16:0] alarm_cause_in,
    input wire logic [6:0] warning_cause_in,
    input wire logic [1:0] hw_limit_in,
    input wire logic [1:0] sw_limit_in,
    input wire logic history_backup_ok_in,
    input wire logic motion_req_in,
    input wire logic motion_plus_in,
    output logic motion_accept_out,
    output logic driver_ready_out,
    output logic warning_out,
    output logic plus_limit_out,
    output logic minus_limit_out,
    output logic servo_state_out,
    output logic servo_on_out,
    output logic dyn_brake_out,
    output sda_led_type power_led_out,
    output logic [15:0] fault_code_out,
    output logic hist_push_out,
    output logic [15:0] hist_code_out,
    output logic irq_out
);
    localparam int CW = $clog2(INIT_LIMIT_CYCLES + 1);

    // ==========================================
    // Code table
    function automatic logic [15:0] alarm_code(input logic [4:0] idx);
        logic [15:0] c;
        c = 16'h3F3F;
        case (idx)
            5'h00: c = 16'h4130;
            5'h01: c = 16'h4131;
            5'h02: c = 16'h4132;
            5'h03: c = 16'h4134;
            5'h04: c = 16'h4139;
            5'h05: c = 16'h4333;
            5'h06: c = 16'h4530;
            5'h07: c = 16'h4532;
            5'h08: c = 16'h4537;
            5'h09: c = 16'h4538;
            5'h0A: c = 16'h4539;
            5'h0B: c = 16'h4634;
            5'h0C: c = 16'h5030;
            5'h0D: c = 16'h5031;
            5'h0E: c = 16'h5032;
            5'h0F: c = 16'h5033;
            5'h10: c = 16'h5039;
            default: c = 16'h3F3F;
        endcase
        return c;
    endfunction

    function automatic logic [15:0] warn_code(input logic [2:0] idx);
        logic [15:0] c;
        c = 16'h3F3F;
        case (idx)
            3'h0: c = 16'h4133;
            3'h1: c = 16'h4135;
            3'h2: c = 16'h4330;
            3'h3: c = 16'h4631;
            3'h4: c = 16'h4635;
            3'h5: c = 16'h4638;
            3'h6: c = 16'h5035;
            default: c = 16'h3F3F;
        endcase
        return c;
    endfunction

    function automatic logic [4:0] lowest17(input logic [16:0] v);
        logic [4:0] r;
        r = 5'h00;
        for (int k = 16; k >= 0; k--) begin
            if (v[k]) begin
                r = 5'(k);
            end
        end
        return r;
    endfunction

    function automatic logic [2:0] lowest7(input logic [6:0] v);
        logic [2:0] r;
        r = 3'h0;
        for (int k = 6; k >= 0; k--) begin
            if (v[k]) begin
                r = 3'(k);
            end
        end
        return r;
    endfunction

    // ==========================================
    // Registers and state
    sda_state_type state;
    sda_state_type next_state;
    logic [1:0] ctrl;
    logic [3:0] irq_mask;
    logic [16:0] tell_snap;
    logic [16:0] hist_pending;
    logic [16:0] alarm_prev;
    logic [1:0] limit_prev;
    logic [6:0] warn_prev;
    logic [15:0] hist_last;
    logic [7:0] hist_count;
    logic [CW-1:0] init_cnt;
    logic init_timeout;
    logic cmd_clear;
    logic cmd_tell;
    logic wr_en;
    logic rd_setup;
    logic addr_ok;

    sda_latch_if #(.W(SDA_ALARMS)) alarm_lt();
    sda_latch_if #(.W(SDA_WARNS)) warn_lt();
    sda_latch_if #(.W(4)) irq_lt();

    sda_event_latch #(.W(SDA_ALARMS)) u_alarm (
        .pclk(pclk),
        .presetn(presetn),
        .lt(alarm_lt.store)
    );
    sda_event_latch #(.W(SDA_WARNS)) u_warn (
        .pclk(pclk),
        .presetn(presetn),
        .lt(warn_lt.store)
    );
    sda_event_latch #(.W(4)) u_irq (
        .pclk(pclk),
        .presetn(presetn),
        .lt(irq_lt.store)
    );

    // ==========================================
    // Abnormality sources
    logic [1:0] limit_act;
    logic any_alarm;
    logic any_warn;
    logic warn_servo_off;
    logic [16:0] recordable;
    logic [16:0] alarm_rise;

    assign limit_act = hw_limit_in | sw_limit_in;
    assign any_alarm = |alarm_lt.q;
    assign any_warn = |warn_lt.q;
    assign warn_servo_off = |(warn_lt.q & `SDA_WARN_SERVO_OFF);

    always_comb begin
        alarm_lt.set = alarm_cause_in;
        alarm_lt.set[`SDA_AL_F4] = emergency_stop_in;
        alarm_lt.set[`SDA_AL_C3] = alarm_cause_in[`SDA_AL_C3] | init_timeout;
        // Only the emergency stop has a way out short of power removal
        alarm_lt.clr = '0;
        alarm_lt.clr[`SDA_AL_F4] = ~emergency_stop_in;
    end

    // Clear request is harmless while a cause is still present: set wins
    assign warn_lt.set = warning_cause_in;
    assign warn_lt.clr = {SDA_WARNS{fault_clear_in | cmd_clear}};

    always_comb begin
        recordable = '1;
        recordable[`SDA_AL_E0] = 1'b0;
        recordable[`SDA_AL_F4] = 1'b0;
        recordable[`SDA_AL_C3] = history_backup_ok_in;
        recordable[`SDA_AL_E2] = history_backup_ok_in;
    end
    assign alarm_rise = alarm_lt.q & ~alarm_prev;

    // ==========================================
    // Processor initialisation watchdog
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            init_cnt <= '0;
            init_timeout <= 1'b0;
        end else if (state == SDA_INIT && !init_done_in) begin
            if (init_cnt == CW'(INIT_LIMIT_CYCLES - 1)) begin
                init_timeout <= 1'b1;
            end else begin
                init_cnt <= init_cnt + CW'(1);
            end
        end
    end

    // ==========================================
    // Servo state machine
    always_comb begin
        next_state = state;
        case (state)
            SDA_INIT: begin
                if (init_timeout) begin
                    next_state = SDA_CPU_FAIL;
                end else if (init_done_in) begin
                    next_state = SDA_SERVO_OFF;
                end
            end
            SDA_SERVO_OFF: begin
                if (any_alarm) begin
                    next_state = SDA_ALARM;
                end else if (servo_enable_in && !warn_servo_off) begin
                    next_state = SDA_ENGAGING;
                end
            end
            SDA_ENGAGING: begin
                if (any_alarm) begin
                    next_state = SDA_ALARM;
                end else if (!servo_enable_in || warn_servo_off) begin
                    next_state = SDA_SERVO_OFF;
                end else if (servo_engaged_in) begin
                    next_state = SDA_RUNNING;
                end
            end
            SDA_RUNNING: begin
                if (any_alarm) begin
                    next_state = SDA_ALARM;
                end else if (!servo_enable_in || warn_servo_off) begin
                    next_state = SDA_SERVO_OFF;
                end
            end
            SDA_ALARM: begin
                if (!any_alarm) begin
                    next_state = SDA_SERVO_OFF;
                end
            end
            SDA_CPU_FAIL: next_state = SDA_CPU_FAIL;
            default: next_state = SDA_INIT;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= SDA_INIT;
        end else begin
            state <= next_state;
        end
    end

    // ==========================================
    // Discrete outputs; closed contact is a high level
    logic ready_closed;
    logic warn_closed;
    logic [1:0] limit_closed;
    logic is_init;

    // A dead processor cannot drive anything, so all contacts open
    assign is_init = (state == SDA_INIT) || (state == SDA_CPU_FAIL);
    assign ready_closed = !is_init && !any_alarm;
    assign warn_closed = !is_init && !any_warn;
    assign limit_closed = is_init ? 2'b00 : ~limit_act;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            driver_ready_out <= 1'b0;
            warning_out <= 1'b0;
            plus_limit_out <= 1'b0;
            minus_limit_out <= 1'b0;
            servo_state_out <= 1'b0;
            servo_on_out <= 1'b0;
            dyn_brake_out <= 1'b1;
        end else begin
            driver_ready_out <= ready_closed;
            // Positive polarity inverts only while the processor runs
            warning_out <= is_init ? 1'b0 :
                (ctrl[`SDA_CTRL_WARN_NEG] ? warn_closed : !warn_closed);
            plus_limit_out <= is_init ? 1'b0 :
                (ctrl[`SDA_CTRL_LIMIT_NEG] ? limit_closed[1] : !limit_closed[1]);
            minus_limit_out <= is_init ? 1'b0 :
                (ctrl[`SDA_CTRL_LIMIT_NEG] ? limit_closed[0] : !limit_closed[0]);
            servo_state_out <= (next_state == SDA_RUNNING);
            servo_on_out <= (next_state == SDA_ENGAGING) || (next_state == SDA_RUNNING);
            dyn_brake_out <= !((next_state == SDA_ENGAGING) ||
                (next_state == SDA_RUNNING));
        end
    end

    // Stop held by the controller blocks every motion; limits block one way only
    assign motion_accept_out = motion_req_in && (state == SDA_RUNNING) && !stop_in &&
        !(motion_plus_in ? limit_act[1] : limit_act[0]);

    // ==========================================
    // Power LED and fault display
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            power_led_out <= SDA_LED_ORANGE;
            fault_code_out <= 16'h2020;
        end else if (is_init) begin
            power_led_out <= SDA_LED_ORANGE;
            fault_code_out <= 16'h2020;
        end else if (any_alarm) begin
            power_led_out <= SDA_LED_ORANGE;
            fault_code_out <= alarm_code(lowest17(alarm_lt.q));
        end else if (any_warn) begin
            power_led_out <= SDA_LED_ORANGE;
            fault_code_out <= warn_code(lowest7(warn_lt.q));
        end else if (|limit_act) begin
            power_led_out <= SDA_LED_ORANGE;
            fault_code_out <= (|hw_limit_in) ? 16'h4633 : 16'h4632;
        end else begin
            power_led_out <= SDA_LED_GREEN;
            // Follows the same next state as the servo-state contact so both change together
            fault_code_out <= (next_state == SDA_RUNNING) ? 16'h2020 : 16'h2043;
        end
    end

    // ==========================================
    // Alarm history: one record per cycle, lowest pending first
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alarm_prev <= '0;
            hist_pending <= '0;
            hist_push_out <= 1'b0;
            hist_code_out <= 16'h0000;
            hist_last <= 16'h0000;
            hist_count <= 8'h00;
        end else begin
            alarm_prev <= alarm_lt.q;
            hist_push_out <= |hist_pending;
            if (|hist_pending) begin
                hist_code_out <= alarm_code(lowest17(hist_pending));
                hist_last <= alarm_code(lowest17(hist_pending));
                hist_count <= hist_count + 8'h01;
                hist_pending <= (hist_pending & ~(17'h00001 << lowest17(hist_pending))) |
                    (alarm_rise & recordable);
            end else begin
                hist_pending <= alarm_rise & recordable;
            end
        end
    end

    // ==========================================
    // Interrupt events
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            warn_prev <= '0;
            limit_prev <= '0;
        end else begin
            warn_prev <= warn_lt.q;
            limit_prev <= limit_act;
        end
    end

    always_comb begin
        irq_lt.set = '0;
        irq_lt.set[`SDA_IRQ_ALARM] = |alarm_rise;
        irq_lt.set[`SDA_IRQ_WARN] = |(warn_lt.q & ~warn_prev);
        irq_lt.set[`SDA_IRQ_LIMIT] = |(limit_act & ~limit_prev);
        irq_lt.set[`SDA_IRQ_HIST] = hist_push_out;
        irq_lt.clr = '0;
        if (wr_en && paddr == `SDA_REG_IRQ_STAT) begin
            irq_lt.clr = pwdata[3:0];
        end
    end
    assign irq_out = |(irq_lt.q & irq_mask);

    // ==========================================
    // APB slave: zero wait states, read data captured in setup
    assign pready = 1'b1;
    assign wr_en = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    always_comb begin
        case (paddr)
            `SDA_REG_CTRL, `SDA_REG_CMD, `SDA_REG_STATUS, `SDA_REG_ALARM,
            `SDA_REG_WARN, `SDA_REG_LIMIT, `SDA_REG_CODE, `SDA_REG_IRQ_STAT,
            `SDA_REG_IRQ_MASK, `SDA_REG_TELL, `SDA_REG_HIST: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end
    assign pslverr = psel && penable && !addr_ok;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= `SDA_CTRL_RESET;
            irq_mask <= `SDA_IRQ_MASK_RESET;
        end else if (wr_en) begin
            if (paddr == `SDA_REG_CTRL) begin
                ctrl <= pwdata[1:0];
            end
            if (paddr == `SDA_REG_IRQ_MASK) begin
                irq_mask <= pwdata[3:0];
            end
        end
    end

    // Commands act as one-cycle pulses in the access cycle
    assign cmd_clear = wr_en && paddr == `SDA_REG_CMD && pwdata[`SDA_CMD_CLEAR];
    assign cmd_tell = wr_en && paddr == `SDA_REG_CMD && pwdata[`SDA_CMD_TELL];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tell_snap <= '0;
        end else if (cmd_tell) begin
            tell_snap <= alarm_lt.q;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_setup) begin
            case (paddr)
                `SDA_REG_CTRL: prdata <= {30'h0, ctrl};
                `SDA_REG_STATUS: prdata <= {22'h0, power_led_out, servo_engaged_in,
                    servo_state_out, state};
                `SDA_REG_ALARM: prdata <= {15'h0, alarm_lt.q};
                `SDA_REG_WARN: prdata <= {25'h0, warn_lt.q};
                `SDA_REG_LIMIT: prdata <= {28'h0, sw_limit_in, hw_limit_in};
                `SDA_REG_CODE: prdata <= {16'h0, fault_code_out};
                `SDA_REG_IRQ_STAT: prdata <= {28'h0, irq_lt.q};
                `SDA_REG_IRQ_MASK: prdata <= {28'h0, irq_mask};
                `SDA_REG_TELL: prdata <= {15'h0, tell_snap};
                `SDA_REG_HIST: prdata <= {8'h0, hist_count, hist_last};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end
endmodule
`default_nettype wire

// ### testbench/sda_host_model.sv
// Host controller model driving servo request, stop and motion lines
`default_nettype none
module sda_host_model (
    input wire logic pclk,
    input wire logic run_req,
    input wire logic hold_stop,
    input wire logic servo_state_out,
    output logic servo_enable_in = 1'b0,
    output logic stop_in = 1'b1,
    output logic motion_req_in = 1'b0
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================
    // Handshake
    // Motion is only asked for once the servo reports closed
    always @(posedge pclk) begin
        servo_enable_in <= run_req;
        stop_in <= hold_stop || !servo_state_out;
        motion_req_in <= run_req && servo_state_out;
    end
endmodule
`default_nettype wire

// ### testbench/sda_top_monitor.sv
// Port-level checks of the alarm and status block
`default_nettype none
module sda_top_monitor
    import sda_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic servo_on_out,
    input wire logic dyn_brake_out,
    input wire logic servo_state_out,
    input wire logic servo_engaged_in,
    input wire logic emergency_stop_in,
    input wire logic driver_ready_out,
    input wire logic hist_push_out,
    input wire logic [15:0] hist_code_out,
    input wire sda_led_type power_led_out,
    input wire logic [15:0] fault_code_out,
    input wire logic motion_accept_out,
    input wire logic stop_in,
    input wire logic [1:0] hw_limit_in,
    input wire logic motion_plus_in
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================
    // Assertions
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_brake_when_off: assert property (!servo_on_out |-> dyn_brake_out)
        else $error("brake released with servo off");
    a_state_after_engage: assert property ($rose(servo_state_out) |-> $past(servo_engaged_in))
        else $error("servo state closed before engage");
    a_estop_opens_ready: assert property (emergency_stop_in |-> ##2 !driver_ready_out)
        else $error("ready stayed closed on stop alarm");
    a_hist_skips_codes: assert property (hist_push_out |-> hist_code_out != 16'h4530
        && hist_code_out != 16'h4634)
        else $error("unrecordable code pushed");
    a_init_all_open: assert property ((power_led_out == SDA_LED_ORANGE
        && fault_code_out == 16'h2020) |-> !driver_ready_out && !servo_on_out)
        else $error("output closed during init");
    a_alarm_sticks: assert property (fault_code_out == 16'h4130 |=> fault_code_out == 16'h4130)
        else $error("latched alarm went away");
    a_servo_off_green: assert property (fault_code_out == 16'h2043
        |-> power_led_out == SDA_LED_GREEN && !servo_state_out)
        else $error("servo off shown wrongly");
    a_motion_needs_go: assert property (motion_accept_out |-> !stop_in && servo_on_out)
        else $error("motion accepted while stopped");
    a_limit_blocks: assert property ((hw_limit_in[1] && $past(hw_limit_in[1]) && motion_plus_in)
        |-> !motion_accept_out)
        else $error("motion into limit accepted");
endmodule
`default_nettype wire

// ### testbench/tb_sda_top.sv
// Self-checking bench of the alarm and status block
`default_nettype none
`include "sda_cfg.svh"
module tb_sda_top
    import sda_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int INIT_CYC = 50;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, se;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, q, prdata;
    logic init_done_in = 0, servo_engaged_in = 0, emergency_stop_in = 0, fault_clear_in = 0;
    logic history_backup_ok_in = 0, motion_plus_in = 0, run_req = 0, hold_stop = 1;
    logic [16:0] alarm_cause_in = 17'h0;
    logic [6:0] warning_cause_in = 7'h0;
    logic [1:0] hw_limit_in = 2'h0, sw_limit_in = 2'h0;
    logic pready, pslverr, motion_accept_out, driver_ready_out, warning_out, plus_limit_out;
    logic minus_limit_out, servo_state_out, servo_on_out, dyn_brake_out, hist_push_out, irq_out;
    logic servo_enable_in, stop_in, motion_req_in;
    logic [15:0] fault_code_out, hist_code_out;
    sda_led_type power_led_out;
    int n_mismatch = 0, checks_done = 0;
    always #20 pclk = ~pclk;
    sda_top #(.INIT_LIMIT_CYCLES(INIT_CYC)) i_dut (.*);
    sda_host_model i_host (.*);
    // ==========================================
    // Tasks
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            n_mismatch++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // Request held until pready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // ==========================================
    // Tests
    initial begin
        cyc(5);
        presetn <= 1'b1;
        cyc(2); #1
        chk(power_led_out, SDA_LED_ORANGE);
        chk({driver_ready_out, warning_out, plus_limit_out, servo_state_out}, 4'h0);
        chk(fault_code_out, 16'h2020);
        apb(0, `SDA_REG_CTRL, 0);
        chk(q, `SDA_CTRL_RESET);
        init_done_in <= 1'b1;
        cyc(3); #1
        chk({driver_ready_out, warning_out, plus_limit_out, minus_limit_out}, 4'hF);
        chk({servo_state_out, fault_code_out}, 17'h02043);
        @(posedge pclk) run_req <= 1'b1;
        cyc(4); #1
        chk({servo_state_out, dyn_brake_out}, 2'b00);
        @(posedge pclk) servo_engaged_in <= 1'b1;
        cyc(4); #1
        chk({driver_ready_out, warning_out, minus_limit_out, servo_state_out}, 4'hF);
        chk({power_led_out, fault_code_out}, {SDA_LED_GREEN, 16'h2020});
        chk(motion_accept_out, 0);
        @(posedge pclk) hold_stop <= 1'b0;
        cyc(3); #1
        chk(motion_accept_out, 1);
        @(posedge pclk) {hw_limit_in, motion_plus_in} <= 3'b101;
        cyc(3); #1
        chk({plus_limit_out, minus_limit_out, motion_accept_out}, 3'b010);
        chk({power_led_out, fault_code_out}, {SDA_LED_ORANGE, 16'h4633});
        @(posedge pclk) motion_plus_in <= 1'b0;
        #1 chk(motion_accept_out, 1);
        apb(1, `SDA_REG_IRQ_MASK, 32'hF);
        #1 chk(irq_out, 1);
        apb(1, `SDA_REG_IRQ_STAT, 32'hF);
        #1 chk(irq_out, 0);
        // Both clear paths; a warning must stay latched until one of them
        for (int k = 0; k < 2; k++) begin
            @(posedge pclk) {hw_limit_in, warning_cause_in} <= 9'h002;
            cyc(3); #1
            chk({warning_out, fault_code_out}, 17'h04135);
            @(posedge pclk) warning_cause_in <= 7'h0;
            cyc(3); #1
            chk(warning_out, 0);
            if (k == 0) apb(1, `SDA_REG_CMD, 32'h1);
            else @(posedge pclk) fault_clear_in <= 1'b1;
            cyc(3);
            fault_clear_in <= 1'b0;
            #1 chk(warning_out, 1);
        end
        apb(0, 8'h3C, 0);
        chk(se, 1);
        chk(q, 0);
        @(posedge pclk) emergency_stop_in <= 1'b1;
        cyc(3); #1
        chk({driver_ready_out, warning_out, servo_on_out, dyn_brake_out}, 4'h5);
        chk(fault_code_out, 16'h4634);
        @(posedge pclk) emergency_stop_in <= 1'b0;
        cyc(4); #1
        chk(driver_ready_out, 1);
        @(posedge pclk) alarm_cause_in <= 17'h10041;
        @(posedge pclk) alarm_cause_in <= 17'h0;
        cyc(6);
        apb(1, `SDA_REG_CMD, 32'h1);
        apb(0, `SDA_REG_ALARM, 0);
        chk(q, 32'h10041);
        chk({driver_ready_out, fault_code_out}, 17'h04130);
        apb(0, `SDA_REG_HIST, 0);
        chk(q[15:0], 16'h5039);
        @(posedge pclk) {presetn, init_done_in} <= 2'b00;
        cyc(2);
        presetn <= 1'b1;
        cyc(INIT_CYC + 10);
        apb(0, `SDA_REG_ALARM, 0);
        chk(q[`SDA_AL_C3], 1);
        chk({power_led_out, driver_ready_out}, {SDA_LED_ORANGE, 1'b0});
        report_and_stop;
    end
    initial begin
        cyc(3000);
        n_mismatch++;
        report_and_stop;
    end
endmodule
bind sda_top sda_top_monitor i_mon (.*);
`default_nettype wire
